// [hdl/cgrb_consts.vh]
// constants for the calibration and pin register bank
// assumes inclusion by the bank top and the bench top
`ifndef CGRB_CONSTS_VH
`define CGRB_CONSTS_VH

// register addresses
`define CGRB_ADDR_OFFSET_LOW   5'h0B
`define CGRB_ADDR_OFFSET_HIGH  5'h0C
`define CGRB_ADDR_RESERVED_0D  5'h0D
`define CGRB_ADDR_GAIN_LOW     5'h0E
`define CGRB_ADDR_GAIN_HIGH    5'h0F
`define CGRB_ADDR_PIN_DIR_LVL  5'h10
`define CGRB_ADDR_PIN_FUNC     5'h11

// reset values
`define CGRB_RST_OFFSET_LOW    8'h00
`define CGRB_RST_OFFSET_HIGH   8'h00
`define CGRB_RST_RESERVED_0D   8'h00
`define CGRB_RST_GAIN_LOW      8'h00
`define CGRB_RST_GAIN_HIGH     8'h40
`define CGRB_RST_PIN_DIR       4'h0
`define CGRB_RST_PIN_LEVEL     4'h0
`define CGRB_RST_PIN_FUNC      4'h0

// field positions in the pin registers
`define CGRB_DIR_MSB           7
`define CGRB_DIR_LSB           4
`define CGRB_LVL_MSB           3
`define CGRB_LVL_LSB           0
`define CGRB_FUNC_MSB          3
`define CGRB_FUNC_LSB          0
`define CGRB_FUNC_UPPER_READ   4'h0

// command byte: opcode in [7:5], address in [4:0]
`define CGRB_OP_READ           3'h1
`define CGRB_OP_WRITE          3'h2

// serial frame: command byte then one data byte
`define CGRB_CMD_LAST_BIT      5'h07
`define CGRB_DATA_LAST_BIT     5'h0F
`define CGRB_FRAME_DONE        5'h10
`define CGRB_UNMAPPED_READ     8'h00

`endif

// [hdl/cgrb_sync.v]
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes dst clock and an already synchronised active-low reset
`timescale 1ns/100ps

module cgrb_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input  wire             clk_sys,
  input  wire             rst_sync_b,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  // first stage feeds only the second stage
  reg [WIDTH-1:0] meta_reg;

  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // cgrb_sync

// [hdl/cgrb_top.v]
// calibration words and four-pin register bank behind a serial slave port
// assumes an external serial master; pins are resolved by the surroundings
// Function
// [RULE1] the upper offset correction byte is read/write and resets to zero.
// [RULE2] the lower offset correction byte is a separate read/write byte resetting to zero.
// [RULE3] the gain correction word is two read/write bytes resetting to 0x00 low and 0x40 high.
// [RULE4] the upper nibble of the pin data register sets direction per pin, zero output by default.
// [RULE5] the lower nibble holds pin levels that drive outputs and report inputs, resetting to zero.
// [RULE6] the low nibble of the pin configuration register picks analog or digital, upper nibble reads zero.
// [RULE7] the reserved byte at 0x0D reads zero and the master writes only zero to reserved bits.
// [RULE8] the serial link uses mode 1: clock idles low, launch on rising edges, sample on falling edges.
// [RULE9] on the six-input variant pins stay disabled until software sets their function bit.
// [RULE10] a pin set as analog input ignores its direction and level bits and keeps its driver off.
`timescale 1ns/100ps

`include "cgrb_consts.vh"

module cgrb_top #(
  parameter PINS      = 4,
  parameter SIX_INPUT = 0
) (
  input  wire            clk_sys,
  input  wire            rst_b,
  input  wire            spi_cs_b,
  input  wire            spi_sclk,
  input  wire            spi_din,
  output reg             spi_dout,
  output reg             spi_dout_oe,
  input  wire [PINS-1:0] pin_in,
  output reg  [PINS-1:0] pin_out,
  output reg  [PINS-1:0] pin_oe,
  output reg  [15:0]     offset_corr_word,
  output reg  [15:0]     gain_corr_word
);

  // reset release
  reg rst_meta_reg;
  reg rst_sync_b;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_b   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_b   <= rst_meta_reg;
    end
  end

  // pin synchronisers
  wire            cs_b_sync;
  wire            sclk_sync;
  wire            din_sync;
  wire [PINS-1:0] pin_sync;

  cgrb_sync #(
    .WIDTH (3),
    .INIT  (3'h4)
  ) u_spi_sync (
    .clk_sys    (clk_sys),
    .rst_sync_b (rst_sync_b),
    .async_in   ({spi_cs_b, spi_sclk, spi_din}),
    .sync_out   ({cs_b_sync, sclk_sync, din_sync})
  );

  cgrb_sync #(
    .WIDTH (PINS),
    .INIT  ({PINS{1'b0}})
  ) u_pin_sync (
    .clk_sys    (clk_sys),
    .rst_sync_b (rst_sync_b),
    .async_in   (pin_in),
    .sync_out   (pin_sync)
  );

  // registers
  reg [7:0]      offset_low_reg;
  reg [7:0]      offset_high_reg;
  reg [7:0]      gain_low_reg;
  reg [7:0]      gain_high_reg;
  reg [PINS-1:0] pin_dir_reg;
  reg [PINS-1:0] pin_level_reg;
  reg [PINS-1:0] pin_func_reg;

  // serial engine state
  reg       sclk_prev_reg;
  reg [4:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [2:0] op_reg;
  reg [4:0] addr_reg;
  reg [7:0] tx_reg;

  wire sclk_fall = sclk_prev_reg & ~sclk_sync;
  wire sclk_rise = ~sclk_prev_reg & sclk_sync;
  wire [7:0] rx_byte = {shift_reg[6:0], din_sync};

  // pin view seen by software
  wire [PINS-1:0] pin_enabled = pin_func_reg;
  wire [PINS-1:0] pin_is_input = pin_enabled & pin_dir_reg;
  wire [PINS-1:0] level_view;
  wire [PINS-1:0] dir_view;

  // inputs report the live level; six-input variant hides disabled pins
  assign level_view = (pin_is_input & pin_sync) | (~pin_is_input & pin_level_reg &
                      (SIX_INPUT ? pin_enabled : {PINS{1'b1}}));                     // [RULE5] [RULE9]
  assign dir_view   = pin_dir_reg;

  function [7:0] read_mux;
    input [4:0]      addr;
    input [7:0]      ofs_lo;
    input [7:0]      ofs_hi;
    input [7:0]      gn_lo;
    input [7:0]      gn_hi;
    input [PINS-1:0] dir_v;
    input [PINS-1:0] lvl_v;
    input [PINS-1:0] func_v;
    begin
      if (addr == `CGRB_ADDR_OFFSET_LOW) begin
        read_mux = ofs_lo;
      end else if (addr == `CGRB_ADDR_OFFSET_HIGH) begin
        read_mux = ofs_hi;
      end else if (addr == `CGRB_ADDR_RESERVED_0D) begin
        read_mux = `CGRB_RST_RESERVED_0D;                                           // [RULE7]
      end else if (addr == `CGRB_ADDR_GAIN_LOW) begin
        read_mux = gn_lo;
      end else if (addr == `CGRB_ADDR_GAIN_HIGH) begin
        read_mux = gn_hi;
      end else if (addr == `CGRB_ADDR_PIN_DIR_LVL) begin
        read_mux = {dir_v, lvl_v};                                                  // [RULE4] [RULE5]
      end else if (addr == `CGRB_ADDR_PIN_FUNC) begin
        read_mux = {`CGRB_FUNC_UPPER_READ, func_v};                                 // [RULE6]
      end else begin
        read_mux = `CGRB_UNMAPPED_READ;
      end
    end
  endfunction

  wire write_now = ~cs_b_sync & sclk_fall & (bit_cnt_reg == `CGRB_DATA_LAST_BIT) &
                   (op_reg == `CGRB_OP_WRITE);

  // frame qualifiers; sclk must stay below an eighth of clk_sys
  wire frame_on   = ~cs_b_sync;
  wire bit_take   = frame_on & sclk_fall & (bit_cnt_reg != `CGRB_FRAME_DONE);
  wire cmd_take   = bit_take & (bit_cnt_reg == `CGRB_CMD_LAST_BIT);
  wire read_phase = (bit_cnt_reg[4:3] == 2'b01) & (op_reg == `CGRB_OP_READ);

  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sclk_prev_reg <= 1'b0;
      spi_dout_oe   <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_sync;
      spi_dout_oe   <= frame_on;
    end
  end

  // bits beyond the sixteenth are ignored
  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bit_cnt_reg <= 5'h00;
    end else if (!frame_on) begin
      bit_cnt_reg <= 5'h00;
    end else if (bit_take) begin                                                  // [RULE8]
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      shift_reg <= 8'h00;
    end else if (bit_take) begin                                                  // [RULE8]
      shift_reg <= rx_byte;
    end
  end

  // read answer frozen at the command byte so it cannot tear mid-shift
  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      op_reg   <= 3'h0;
      addr_reg <= 5'h00;
      tx_reg   <= 8'h00;
    end else if (!frame_on) begin
      op_reg   <= 3'h0;
    end else if (cmd_take) begin
      op_reg   <= rx_byte[7:5];
      addr_reg <= rx_byte[4:0];
      tx_reg   <= read_mux(rx_byte[4:0], offset_low_reg, offset_high_reg,
                           gain_low_reg, gain_high_reg, dir_view, level_view, pin_func_reg);
    end
  end

  // data leaves on rising edges during the data byte of a read
  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      spi_dout <= 1'b0;
    end else if (!frame_on) begin
      spi_dout <= 1'b0;
    end else if (sclk_rise) begin                                                 // [RULE8]
      if (read_phase) begin
        spi_dout <= tx_reg[~bit_cnt_reg[2:0]];
      end else begin
        spi_dout <= 1'b0;
      end
    end
  end

  // address compare shared by every write strobe
  function addr_hit;
    input [4:0] addr;
    input [4:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // one strobe per stored byte; reserved 0x0D and unmapped addresses get none
  wire wr_offset_low  = write_now & addr_hit(addr_reg, `CGRB_ADDR_OFFSET_LOW);
  wire wr_offset_high = write_now & addr_hit(addr_reg, `CGRB_ADDR_OFFSET_HIGH);
  wire wr_gain_low    = write_now & addr_hit(addr_reg, `CGRB_ADDR_GAIN_LOW);
  wire wr_gain_high   = write_now & addr_hit(addr_reg, `CGRB_ADDR_GAIN_HIGH);
  wire wr_pin_dir_lvl = write_now & addr_hit(addr_reg, `CGRB_ADDR_PIN_DIR_LVL);
  wire wr_pin_func    = write_now & addr_hit(addr_reg, `CGRB_ADDR_PIN_FUNC);

  // stored bytes; upper function nibble has no storage
  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      offset_low_reg <= `CGRB_RST_OFFSET_LOW;                                       // [RULE2]
    end else if (wr_offset_low) begin
      offset_low_reg <= rx_byte;                                                    // [RULE2]
    end
  end

  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      offset_high_reg <= `CGRB_RST_OFFSET_HIGH;                                     // [RULE1]
    end else if (wr_offset_high) begin
      offset_high_reg <= rx_byte;                                                   // [RULE1]
    end
  end

  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      gain_low_reg <= `CGRB_RST_GAIN_LOW;                                           // [RULE3]
    end else if (wr_gain_low) begin
      gain_low_reg <= rx_byte;                                                      // [RULE3]
    end
  end

  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      gain_high_reg <= `CGRB_RST_GAIN_HIGH;                                         // [RULE3]
    end else if (wr_gain_high) begin
      gain_high_reg <= rx_byte;                                                     // [RULE3]
    end
  end

  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_dir_reg <= `CGRB_RST_PIN_DIR;                                             // [RULE4]
    end else if (wr_pin_dir_lvl) begin
      pin_dir_reg <= rx_byte[`CGRB_DIR_MSB:`CGRB_DIR_LSB];                          // [RULE4]
    end
  end

  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_level_reg <= `CGRB_RST_PIN_LEVEL;                                         // [RULE5]
    end else if (wr_pin_dir_lvl) begin
      pin_level_reg <= rx_byte[`CGRB_LVL_MSB:`CGRB_LVL_LSB];                        // [RULE5]
    end
  end

  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_func_reg <= `CGRB_RST_PIN_FUNC;                                           // [RULE6] [RULE9]
    end else if (wr_pin_func) begin
      pin_func_reg <= rx_byte[`CGRB_FUNC_MSB:`CGRB_FUNC_LSB];                       // [RULE6] [RULE7]
    end
  end

  // outputs from flops, one cycle behind the stored bytes
  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      offset_corr_word <= {`CGRB_RST_OFFSET_HIGH, `CGRB_RST_OFFSET_LOW};
    end else begin
      offset_corr_word <= {offset_high_reg, offset_low_reg};                        // [RULE1] [RULE2]
    end
  end

  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      gain_corr_word <= {`CGRB_RST_GAIN_HIGH, `CGRB_RST_GAIN_LOW};
    end else begin
      gain_corr_word <= {gain_high_reg, gain_low_reg};                              // [RULE3]
    end
  end

  // analog pins never drive, whatever direction says
  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_oe <= {PINS{1'b0}};
    end else begin
      pin_oe <= pin_enabled & ~pin_dir_reg;                                         // [RULE10] [RULE9] [RULE4]
    end
  end

  always @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_out <= {PINS{1'b0}};
    end else begin
      pin_out <= pin_enabled & ~pin_dir_reg & pin_level_reg;                        // [RULE10] [RULE5]
    end
  end

endmodule // cgrb_top

// [testbench/cgrb_top_sva.sv]
// port checker for the calibration and pin bank
// assumes one clock domain and a bind from the bench top
`timescale 1ns/100ps
module cgrb_top_sva #(
  parameter PINS = 4
) (
  input wire            clk_sys,
  input wire            rst_b,
  input wire            spi_cs_b,
  input wire            spi_sclk,
  input wire            spi_din,
  input wire            spi_dout,
  input wire            spi_dout_oe,
  input wire [PINS-1:0] pin_in,
  input wire [PINS-1:0] pin_out,
  input wire [PINS-1:0] pin_oe,
  input wire [15:0]     offset_corr_word,
  input wire [15:0]     gain_corr_word
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_level_needs_driver: assert property ((pin_out & ~pin_oe) == 0) else $error("level on undriven pin");
  a_reset_words: assert property ($rose(rst_b) |-> offset_corr_word == 16'h0000 && gain_corr_word == 16'h4000)
    else $error("word reset value wrong");
  a_reset_pins_off: assert property ($rose(rst_b) |-> pin_oe == 0 && pin_out == 0)
    else $error("pins driven at reset");
  a_ofs_at_frame_end: assert property ($changed(offset_corr_word) |-> !spi_cs_b && !spi_sclk)
    else $error("offset word moved mid frame");
  a_gain_at_frame_end: assert property ($changed(gain_corr_word) |-> !spi_cs_b && !spi_sclk)
    else $error("gain word moved mid frame");
  a_pins_at_frame_end: assert property ($changed({pin_oe, pin_out}) |-> !spi_cs_b && !spi_sclk)
    else $error("pin drive moved mid frame");
  a_dout_after_rise: assert property ($changed(spi_dout) |-> $past(spi_sclk, 3) || $past(spi_cs_b, 3))
    else $error("data out moved off a rising edge");
  a_oe_on_select: assert property ($fell(spi_cs_b) |-> ##[1:4] spi_dout_oe)
    else $error("data out not enabled");
  a_quiet_when_idle: assert property (spi_cs_b [*6] |-> !spi_dout_oe && !spi_dout)
    else $error("data out busy idle");
  cover property ($changed(gain_corr_word));
  cover property ($rose(spi_dout));
  cover property ($rose(pin_oe[0]));
endmodule // cgrb_top_sva

// [testbench/cgrb_spi_master.sv]
// serial master model for the bank, mode 1, one register per frame
// assumes the bench calls xfer and holds clk_sys running
`timescale 1ns/100ps
module cgrb_spi_master (
  input  wire clk_sys,
  output reg  spi_cs_b,
  output reg  spi_sclk,
  output reg  spi_din,
  input  wire spi_dout
);
  initial begin
    spi_cs_b = 1'b1;
    spi_sclk = 1'b0;
    spi_din  = 1'b0;
  end
  // six cycles a phase keeps well above the 4-cycle minimum
  task half;
    repeat (6) @(negedge clk_sys);
  endtask
  task xfer(input [7:0] cmd, input [7:0] dat, input integer nbits, output [7:0] rdat);
    reg [15:0] sh;
    integer    i;
    begin
      sh = {cmd, dat};
      rdat = 8'h00;
      @(negedge clk_sys);
      spi_cs_b = 1'b0;
      half;
      for (i = 0; i < nbits; i = i + 1) begin
        spi_sclk = 1'b1;
        spi_din = sh[15-i];
        half;
        spi_sclk = 1'b0;
        if (i > 7) rdat = {rdat[6:0], spi_dout};
        half;
      end
      spi_cs_b = 1'b1;
      spi_din = ~spi_din; // released line shows no stale bit
      half;
      half;
    end
  endtask
endmodule // cgrb_spi_master

// [testbench/test_cgrb_top.sv]
// self-checking bench for the calibration and pin bank
// assumes the serial master model and the port checker
`timescale 1ns/100ps
`include "cgrb_consts.vh"
module test_cgrb_top;
  reg         clk_sys = 1'b0;
  reg         rst_b = 1'b0;
  reg  [3:0]  pin_in = 4'hA;
  wire        spi_cs_b, spi_sclk, spi_din, spi_dout, spi_dout_oe;
  wire [3:0]  pin_out, pin_oe;
  wire [15:0] offset_corr_word, gain_corr_word;
  integer     n_fail = 0;
  integer     checked = 0;
  reg  [7:0]  junk;
  always #2 clk_sys = ~clk_sys;
  cgrb_top cgrb_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .spi_cs_b(spi_cs_b), .spi_sclk(spi_sclk),
    .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .offset_corr_word(offset_corr_word), .gain_corr_word(gain_corr_word));
  cgrb_spi_master cgrb_spi_master_i (.clk_sys(clk_sys), .spi_cs_b(spi_cs_b), .spi_sclk(spi_sclk),
    .spi_din(spi_din), .spi_dout(spi_dout));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    cgrb_spi_master_i.xfer({`CGRB_OP_WRITE, a}, d, 16, junk);
  endtask
  task rd(input [4:0] a, input [7:0] e);
    begin
      cgrb_spi_master_i.xfer({`CGRB_OP_READ, a}, 8'h00, 16, junk);
      chk(junk, e);
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(offset_corr_word, 16'h0000);
    chk(gain_corr_word, 16'h4000);
    chk(pin_oe, 4'h0);
    chk({spi_dout_oe, spi_dout}, 2'h0);
    rd(`CGRB_ADDR_OFFSET_LOW, 8'h00);
    rd(`CGRB_ADDR_OFFSET_HIGH, 8'h00);
    rd(`CGRB_ADDR_RESERVED_0D, 8'h00);
    rd(`CGRB_ADDR_GAIN_LOW, 8'h00);
    rd(`CGRB_ADDR_GAIN_HIGH, 8'h40);
    rd(`CGRB_ADDR_PIN_DIR_LVL, 8'h00);
    rd(`CGRB_ADDR_PIN_FUNC, 8'h00);
    $display("test reset values done");
    wr(`CGRB_ADDR_OFFSET_LOW, 8'hA5);
    wr(`CGRB_ADDR_OFFSET_HIGH, 8'h5A);
    chk(offset_corr_word, 16'h5AA5);
    wr(`CGRB_ADDR_GAIN_LOW, 8'h34);
    wr(`CGRB_ADDR_GAIN_HIGH, 8'h12);
    chk(gain_corr_word, 16'h1234);
    rd(`CGRB_ADDR_OFFSET_HIGH, 8'h5A);
    rd(`CGRB_ADDR_GAIN_LOW, 8'h34);
    $display("test calibration words done");
    wr(`CGRB_ADDR_RESERVED_0D, 8'h00);
    rd(`CGRB_ADDR_RESERVED_0D, 8'h00);
    wr(`CGRB_ADDR_PIN_FUNC, 8'h0F);
    rd(`CGRB_ADDR_PIN_FUNC, 8'h0F);
    cgrb_spi_master_i.xfer({`CGRB_OP_WRITE, `CGRB_ADDR_GAIN_HIGH}, 8'h77, 12, junk);
    chk(gain_corr_word, 16'h1234);
    rd(5'h1F, 8'h00);
    $display("test refused accesses done");
    chk(pin_oe, 4'hF);
    wr(`CGRB_ADDR_PIN_DIR_LVL, 8'h05);
    chk(pin_out, 4'h5);
    wr(`CGRB_ADDR_PIN_DIR_LVL, 8'hF0);
    chk(pin_oe, 4'h0);
    rd(`CGRB_ADDR_PIN_DIR_LVL, 8'hFA);
    pin_in = 4'h5;
    rd(`CGRB_ADDR_PIN_DIR_LVL, 8'hF5);
    wr(`CGRB_ADDR_PIN_FUNC, 8'h00);
    wr(`CGRB_ADDR_PIN_DIR_LVL, 8'h05);
    chk({pin_oe, pin_out}, 8'h00);
    rd(`CGRB_ADDR_PIN_DIR_LVL, 8'h05);
    $display("test pins done");
    tally_and_finish;
  end
endmodule // test_cgrb_top
bind cgrb_top cgrb_top_sva #(.PINS(PINS)) cgrb_top_sva_i (.clk_sys(clk_sys), .rst_b(rst_b), .spi_cs_b(spi_cs_b),
  .spi_sclk(spi_sclk), .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .offset_corr_word(offset_corr_word), .gain_corr_word(gain_corr_word));
